//--- cp_current_scale.v
/*
 Maps the four-bit charge pump code to a relative current,
 base times two to the power code/4. Output = mantissa shifted by code/4.
 Assumes single clock; output is registered.
*/
`timescale 1ns/100ps

module cp_current_scale
(
   clk,
   rst,
   code,
   current
);
   input wire clk;
   input wire rst;
   input wire [3:0] code;
   output reg [15:0] current;

   // Quarter-octave mantissa, 128 = 2^0, rounded 2^(k/4)*128
   function [7:0] mantissa;
      input [1:0] frac;
      begin
         case (frac)
            2'd0: mantissa = 8'h8_0;
            2'd1: mantissa = 8'h9_8;
            2'd2: mantissa = 8'hb_5;
            2'd3: mantissa = 8'hd_7;
            default: mantissa = 8'h8_0;
         endcase
      end
   endfunction

   always @(posedge clk)
   begin
      if (rst)
      begin
         current <= 16'h0_080;
      end
      else
      begin
         current <= {8'h0_0, mantissa(code[1:0])} << code[3:2]; // see R3
      end
   end
endmodule

//--- masked_byte_reg.v
/*
 One byte register with a write mask, a synchronous reset value and a
 hardware load port. Assumes single clock and synchronous active-high reset.
*/
`timescale 1ns/100ps

module masked_byte_reg
#(
   parameter [7:0] RESET_VALUE = 8'h0_0,
   parameter [7:0] WRITE_MASK = 8'hf_f
)
(
   clk,
   rst,
   restore,
   sw_write,
   sw_data,
   hw_load,
   hw_mask,
   hw_data,
   value
);
   input wire clk;
   input wire rst;
   input wire restore;
   input wire sw_write;
   input wire [7:0] sw_data;
   input wire hw_load;
   input wire [7:0] hw_mask;
   input wire [7:0] hw_data;
   output wire [7:0] value;

   reg [7:0] value_reg;
   reg [7:0] value_next;

   // Hardware result load wins over a software write in the same cycle,
   // so a completing calibration is lost only to rst or restore, never to a software write.
   always @*
   begin
      value_next = value_reg;
      if (sw_write)
      begin
         value_next = (value_reg & ~WRITE_MASK) | (sw_data & WRITE_MASK); // see R9
      end
      if (hw_load)
      begin
         value_next = (value_next & ~hw_mask) | (hw_data & hw_mask & WRITE_MASK); // see R10
      end
   end

   always @(posedge clk)
   begin
      if (rst || restore)
      begin
         value_reg <= RESET_VALUE; // see R6
      end
      else
      begin
         value_reg <= value_next;
      end
   end

   assign value = value_reg;
endmodule

//--- synth_cal_chk_properties.sv
/* Port checker for synth_calibration_regs.
   Assumes one clock and a synchronous active-high reset. */
`timescale 1ns/100ps
module synth_cal_chk
(
   input clk,
   input rst,
   input [15:0] addr,
   input [7:0] wdata,
   input wr_en,
   input rd_en,
   input [7:0] rdata,
   input wake_from_deep_sleep,
   input cal_done,
   input [3:0] cal_charge_pump_result,
   input [4:0] cal_vco_current_result,
   input [5:0] cal_vco_capacitor_result,
   input [1:0] charge_pump_config,
   input charge_pump_cal_enable,
   input [3:0] charge_pump_code,
   input [15:0] charge_pump_current,
   input vco_core_high_select,
   input [4:0] vco_current_code,
   input [5:0] vco_capacitor_code
);
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   // ----------------
   // Read port
   // ----------------
   chk_rdata_idle_zero: assert property (!$past(rd_en) |-> rdata == 8'h00)
      else $error("rdata not zero outside read");
   chk_upper_bits_zero: assert property ($past(rd_en) && $past(addr) != 16'hdf1c |-> !rdata[7:6])
      else $error("unused high bits read nonzero");
   chk_cp_bit_zero: assert property ($past(rd_en) && $past(addr) == 16'hdf1c |-> !rdata[4])
      else $error("unused charge pump bit read nonzero");
   // ----------------
   // Result fields
   // ----------------
   chk_cap_write_used: assert property (wr_en && addr == 16'hdf1e && !cal_done
      && !wake_from_deep_sleep |-> ##2 vco_capacitor_code == $past(wdata[5:0], 2))
      else $error("written capacitor value not used");
   chk_cp_write_used: assert property (wr_en && addr == 16'hdf1c && !cal_done
      |-> ##2 charge_pump_code == $past(wdata[3:0], 2)
      && charge_pump_config == $past(wdata[7:6], 2)
      && charge_pump_cal_enable == $past(wdata[5], 2))
      else $error("written charge pump value not used");
   chk_vi_write_used: assert property (wr_en && addr == 16'hdf1d && !cal_done
      && !wake_from_deep_sleep |-> ##2 vco_current_code == $past(wdata[4:0], 2)
      && vco_core_high_select == $past(wdata[5], 2))
      else $error("written VCO current value not used");
   chk_cal_vi_load: assert property (cal_done && !wake_from_deep_sleep
      |-> ##2 vco_current_code == $past(cal_vco_current_result, 2))
      else $error("VCO current result not loaded");
   chk_cal_cap_load: assert property (cal_done && !wake_from_deep_sleep
      |-> ##2 vco_capacitor_code == $past(cal_vco_capacitor_result, 2))
      else $error("capacitor result not loaded");
   chk_wake_restore: assert property (wake_from_deep_sleep |-> ##2 vco_capacitor_code == 6'h20
      && vco_current_code == 5'h0a && !vco_core_high_select)
      else $error("wake did not restore reset values");
   chk_cp_stage_skip: assert property (cal_done && !wr_en && !$past(wr_en)
      && !charge_pump_cal_enable |-> ##2 $stable(charge_pump_code))
      else $error("charge pump result loaded while disabled");
   chk_cp_stage_load: assert property (cal_done && !wr_en && !$past(wr_en) && charge_pump_cal_enable
      |-> ##2 charge_pump_code == $past(cal_charge_pump_result, 2))
      else $error("charge pump result not loaded");
   // Current and code are registered from the same stored field, so they align
   chk_cp_current_scale: assert property (charge_pump_code[1:0] == 2'b00
      |-> charge_pump_current == 16'h0080 << charge_pump_code[3:2])
      else $error("charge pump current off scale");
   cover property (cal_done);
   cover property (wake_from_deep_sleep);
   cover property ($past(rd_en) && rdata != 8'h00);
endmodule
bind synth_calibration_regs synth_cal_chk chk_i (.*);

//--- synth_cal_map.vh
/*
 Synthesizer calibration register map: offsets, field positions, reset values.
 Included by the register bank only; its helper modules do not include it.
*/
`ifndef SYNTH_CAL_MAP_VH
`define SYNTH_CAL_MAP_VH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define SYNTH_CAL_CHARGE_PUMP_ADDR 16'hdf1c
`define SYNTH_CAL_VCO_CURRENT_ADDR 16'hdf1d
`define SYNTH_CAL_VCO_CAPACITOR_ADDR 16'hdf1e

// ----------------------------------------
// Charge pump register fields
// ----------------------------------------
`define CP_CONFIG_MSB 7
`define CP_CONFIG_LSB 6
`define CP_CAL_ENABLE_BIT 5
`define CP_RESULT_MSB 3
`define CP_RESULT_LSB 0
`define CP_WRITE_MASK 8'he_f
`define CP_RESET 8'h2_a

// ----------------------------------------
// VCO current register fields
// ----------------------------------------
`define VCO_CORE_HIGH_BIT 5
`define VCO_CURRENT_MSB 4
`define VCO_CURRENT_LSB 0
`define VCO_CURRENT_WRITE_MASK 8'h3_f
`define VCO_CURRENT_RESET 8'h0_a

// ----------------------------------------
// VCO capacitor register fields
// ----------------------------------------
`define VCO_CAP_MSB 5
`define VCO_CAP_LSB 0
`define VCO_CAP_WRITE_MASK 8'h3_f
`define VCO_CAP_RESET 8'h2_0

// ----------------------------------------
// Current scale: quarter-octave mantissa table width
// ----------------------------------------
`define CP_MANTISSA_WIDTH 8

`endif

//--- synth_calibration_regs.v
/*
 Synthesizer calibration register bank: charge pump, VCO current and VCO
 capacitor registers on a plain strobe bus, with read data one cycle later.
 Assumes the calibration engine reports results with cal_done and reads
 its controls from the outputs here; wake_from_deep_sleep pulses when the
 chip returns to active mode from sleep_mode_two or sleep_mode_three.
*/
//
// Function
// R1 - Software loads recommended charge pump configuration before starting calibration.
// R2 - Charge pump calibration stage is skipped when its enable bit is zero.
// R3 - Charge pump current equals base times two to the result over four.
// R4 - VCO register: bit 5 core select, bits 4:0 current, reset 01010.
// R5 - Capacitor register holds six-bit coarse tuning result, resets to 100000.
// R6 - VCO current and capacitor registers reset on wake from deep sleep.
// R7 - Software may pre-calibrate each channel and store the three results.
// R8 - Results written back by software are used instead of recalibrating.
// R9 - Unused bits read zero and ignore writes.
// R10 - Completed calibration overwrites result fields with new values.
`timescale 1ns/100ps
`include "synth_cal_map.vh"

module synth_calibration_regs
(
   clk,
   rst,
   addr,
   wdata,
   wr_en,
   rd_en,
   rdata,
   wake_from_deep_sleep,
   cal_done,
   cal_charge_pump_result,
   cal_vco_current_result,
   cal_vco_capacitor_result,
   charge_pump_config,
   charge_pump_cal_enable,
   charge_pump_code,
   charge_pump_current,
   vco_core_high_select,
   vco_current_code,
   vco_capacitor_code
);
   input wire clk;
   input wire rst;
   input wire [15:0] addr;
   input wire [7:0] wdata;
   input wire wr_en;
   input wire rd_en;
   output reg [7:0] rdata;
   input wire wake_from_deep_sleep;
   input wire cal_done;
   input wire [3:0] cal_charge_pump_result;
   input wire [4:0] cal_vco_current_result;
   input wire [5:0] cal_vco_capacitor_result;
   output reg [1:0] charge_pump_config;
   output reg charge_pump_cal_enable;
   output reg [3:0] charge_pump_code;
   output wire [15:0] charge_pump_current;
   output reg vco_core_high_select;
   output reg [4:0] vco_current_code;
   output reg [5:0] vco_capacitor_code;

   // ----------------------------------------
   // Address decode
   // ----------------------------------------
   function hit;
      input [15:0] a;
      input [15:0] target;
      begin
         hit = (a == target);
      end
   endfunction

   wire sel_cp = hit(addr, `SYNTH_CAL_CHARGE_PUMP_ADDR);
   wire sel_vi = hit(addr, `SYNTH_CAL_VCO_CURRENT_ADDR);
   wire sel_vc = hit(addr, `SYNTH_CAL_VCO_CAPACITOR_ADDR);

   wire [7:0] cp_value;
   wire [7:0] vi_value;
   wire [7:0] vc_value;

   wire charge_pump_cal_enable_w;
   assign charge_pump_cal_enable_w = cp_value[`CP_CAL_ENABLE_BIT];

   // Skipped stage leaves the charge pump result untouched
   wire [7:0] cp_hw_mask = charge_pump_cal_enable_w ? 8'h0_f : 8'h0_0; // see R2

   // ----------------------------------------
   // Register storage
   // ----------------------------------------
   // Charge pump register is not among those cleared by deep sleep wake.
   masked_byte_reg
   #(
      .RESET_VALUE(`CP_RESET),
      .WRITE_MASK(`CP_WRITE_MASK)
   )
   u_cp
   (
      .clk(clk),
      .rst(rst),
      .restore(1'b0),
      .sw_write(wr_en && sel_cp), // see R1
      .sw_data(wdata),
      .hw_load(cal_done),
      .hw_mask(cp_hw_mask),
      .hw_data({4'h0, cal_charge_pump_result}),
      .value(cp_value)
   );

   masked_byte_reg
   #(
      .RESET_VALUE(`VCO_CURRENT_RESET),
      .WRITE_MASK(`VCO_CURRENT_WRITE_MASK)
   )
   u_vi
   (
      .clk(clk),
      .rst(rst),
      .restore(wake_from_deep_sleep), // see R6
      .sw_write(wr_en && sel_vi), // see R4
      .sw_data(wdata),
      .hw_load(cal_done),
      .hw_mask(8'h1_f),
      .hw_data({3'h0, cal_vco_current_result}),
      .value(vi_value)
   );

   masked_byte_reg
   #(
      .RESET_VALUE(`VCO_CAP_RESET),
      .WRITE_MASK(`VCO_CAP_WRITE_MASK)
   )
   u_vc
   (
      .clk(clk),
      .rst(rst),
      .restore(wake_from_deep_sleep), // see R6
      .sw_write(wr_en && sel_vc), // see R5
      .sw_data(wdata),
      .hw_load(cal_done),
      .hw_mask(8'h3_f),
      .hw_data({2'h0, cal_vco_capacitor_result}),
      .value(vc_value)
   );

   cp_current_scale u_scale
   (
      .clk(clk),
      .rst(rst),
      .code(cp_value[`CP_RESULT_MSB:`CP_RESULT_LSB]),
      .current(charge_pump_current)
   );

   // ----------------------------------------
   // Control outputs, registered
   // ----------------------------------------
   // Outputs lag the stored value by one cycle; software-written results
   // reach the synthesizer directly, so a hop needs no calibration run.
   always @(posedge clk)
   begin
      if (rst)
      begin
         charge_pump_config <= 2'b00;
         charge_pump_cal_enable <= 1'b1;
         charge_pump_code <= 4'ha;
         vco_core_high_select <= 1'b0;
         vco_current_code <= 5'h0a;
         vco_capacitor_code <= 6'h20;
      end
      else
      begin
         charge_pump_config <= cp_value[`CP_CONFIG_MSB:`CP_CONFIG_LSB];
         charge_pump_cal_enable <= cp_value[`CP_CAL_ENABLE_BIT]; // see R2
         charge_pump_code <= cp_value[`CP_RESULT_MSB:`CP_RESULT_LSB]; // see R8
         vco_core_high_select <= vi_value[`VCO_CORE_HIGH_BIT]; // see R4
         vco_current_code <= vi_value[`VCO_CURRENT_MSB:`VCO_CURRENT_LSB]; // see R8
         vco_capacitor_code <= vc_value[`VCO_CAP_MSB:`VCO_CAP_LSB]; // see R8
      end
   end

   // ----------------------------------------
   // Read port
   // ----------------------------------------
   // Unmapped addresses read zero; data stands only in the cycle after rd_en.
   always @(posedge clk)
   begin
      if (rst)
      begin
         rdata <= 8'h0_0;
      end
      else if (rd_en)
      begin
         if (sel_cp)
         begin
            rdata <= cp_value;
         end
         else if (sel_vi)
         begin
            rdata <= vi_value; // see R9
         end
         else if (sel_vc)
         begin
            rdata <= vc_value; // see R9
         end
         else
         begin
            rdata <= 8'h0_0;
         end
      end
      else
      begin
         rdata <= 8'h0_0;
      end
   end
endmodule

//--- tb_synth_calibration_regs.sv
/* Self-checking bench for synth_calibration_regs.
   Drives all inputs itself; reads land one cycle after the strobe. */
`timescale 1ns/100ps
module tb_synth_calibration_regs;
   logic clk = 0;
   logic rst = 1;
   logic wr_en = 0, rd_en = 0, cal_done = 0, wake_from_deep_sleep = 0;
   logic [15:0] addr = 16'h0000;
   logic [7:0] wdata = 8'h00;
   logic [3:0] cal_charge_pump_result = 4'h0;
   logic [4:0] cal_vco_current_result = 5'h00;
   logic [5:0] cal_vco_capacitor_result = 6'h00;
   logic [7:0] rdata;
   logic [1:0] charge_pump_config;
   logic charge_pump_cal_enable, vco_core_high_select;
   logic [3:0] charge_pump_code;
   logic [15:0] charge_pump_current;
   logic [4:0] vco_current_code;
   logic [5:0] vco_capacitor_code;
   int errors = 0, n_checks = 0;
   synth_calibration_regs uut (.*);
   // ----------------
   // Bus tasks
   // ----------------
   task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      n_checks++;
      if (g !== e)
      begin
         errors++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask
   task wr(input logic [15:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr_en <= 1'b1;
      @(posedge clk);
      wr_en <= 1'b0;
   endtask
   task rd(input logic [15:0] a, input logic [7:0] e);
      @(posedge clk);
      addr <= a;
      rd_en <= 1'b1;
      @(posedge clk);
      rd_en <= 1'b0;
      #1 chk("rdata", {8'h00, e}, {8'h00, rdata});
   endtask
   task cal(input logic [3:0] c, input logic [4:0] v, input logic [5:0] k);
      @(posedge clk);
      cal_charge_pump_result <= c;
      cal_vco_current_result <= v;
      cal_vco_capacitor_result <= k;
      cal_done <= 1'b1;
      @(posedge clk);
      cal_done <= 1'b0;
   endtask
   // ----------------
   // Scenarios
   // ----------------
   task t_access;
      wr(16'hdf1c, 8'hff);
      wr(16'hdf1d, 8'hff);
      wr(16'hdf1e, 8'hff);
      wr(16'hdf1f, 8'h55);
      rd(16'hdf1c, 8'hef);
      rd(16'hdf1d, 8'h3f);
      rd(16'hdf1e, 8'h3f);
      rd(16'hdf1f, 8'h00);
      wr(16'hdf1c, 8'h07);
      repeat (2) @(posedge clk);
      #1 chk("current", 16'h01ae, charge_pump_current);
   endtask
   task t_cal;
      wr(16'hdf1c, 8'h20);
      cal(4'h9, 5'h11, 6'h2b);
      rd(16'hdf1c, 8'h29);
      rd(16'hdf1d, 8'h31);
      rd(16'hdf1e, 8'h2b);
      wr(16'hdf1c, 8'h05);
      cal(4'hc, 5'h03, 6'h01);
      rd(16'hdf1c, 8'h05);
      rd(16'hdf1e, 8'h01);
   endtask
   task t_wake;
      wr(16'hdf1d, 8'h35);
      wr(16'hdf1e, 8'h11);
      @(posedge clk);
      wake_from_deep_sleep <= 1'b1;
      @(posedge clk);
      wake_from_deep_sleep <= 1'b0;
      rd(16'hdf1d, 8'h0a);
      rd(16'hdf1e, 8'h20);
      rd(16'hdf1c, 8'h05);
   endtask
   task t_hop;
      wr(16'hdf1c, 8'he0);
      cal(4'h6, 5'h0d, 6'h1c);
      rd(16'hdf1c, 8'he6);
      rd(16'hdf1d, 8'h0d);
      rd(16'hdf1e, 8'h1c);
      cal(4'h1, 5'h02, 6'h03);
      wr(16'hdf1c, 8'he6);
      wr(16'hdf1d, 8'h2d);
      wr(16'hdf1e, 8'h1c);
      @(posedge clk);
      #1 chk("config", 16'h0003, {14'h0000, charge_pump_config});
      chk("cal_enable", 16'h0001, {15'h0000, charge_pump_cal_enable});
      chk("cp_code", 16'h0006, {12'h000, charge_pump_code});
      chk("core_high", 16'h0001, {15'h0000, vco_core_high_select});
      chk("vco_current", 16'h000d, {11'h000, vco_current_code});
      chk("vco_cap", 16'h001c, {10'h000, vco_capacitor_code});
      chk("current", 16'h016a, charge_pump_current);
   endtask
   task wrap_up;
      $display("checks %0d errors %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   initial forever #25 clk = ~clk;
   initial
   begin
      repeat (2000) @(posedge clk);
      errors++;
      wrap_up;
   end
   initial
   begin
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      rd(16'hdf1c, 8'h2a);
      rd(16'hdf1d, 8'h0a);
      rd(16'hdf1e, 8'h20);
      t_access;
      t_cal;
      t_wake;
      t_hop;
      wrap_up;
   end
endmodule
